// file: hw/pin_block.sv
// Top of the pin block: control and data registers, pins three and four
// Contract
// - Control register at write 1111_0001, read 11100, resets to zero.
// - Control bit 0 set makes pin four an alert source when it is set as input.
// - Control bit 1 sets pin four direction: 0 output, 1 input.
// - Control bit 2 sets pin four active level: 0 low, 1 high.
// - Control bit 4 set makes pin three an alert source when it is a general pin set as input.
// - Control bit 5 sets pin three direction: 0 output, 1 input.
// - Control bit 6 sets pin three active level: 0 low, 1 high.
// - Control bit 7 selects pin three: 0 analog input, 1 general pin.
// - Data register at write 1111_0010, read 11101; bits 4..7 pins four..one.
`timescale 1ns/1ns
`default_nettype none

module pin_block
  import pin_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register write and read access
  input wire write_req_type wr_req,
  input wire read_req_type rd_req,
  output read_rsp_type rd_rsp,
  // Pins three (bit 0) and four (bit 1)
  input wire logic [1:0] pin_in,
  output pin_drive_type pin_drive,
  // Pins one and two data, owned elsewhere
  input wire logic [1:0] pin_low_level,
  output logic [1:0] pin_low_data,
  // Pin events and role
  output logic pin_alert,
  output logic third_auxiliary_input_select
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] data;
    read_rsp_type rsp;
    pin_drive_type drive;
    logic alert;
    logic aux_sel;
  } top_state_type;

  top_state_type s_q;
  top_state_type s_d;

  logic ctrl_we;
  logic data_we;
  logic [7:0] wdata;
  logic [1:0] cell_out;
  logic [1:0] cell_oe;
  logic [1:0] cell_level;
  logic [1:0] cell_alert;
  logic [1:0] cell_en;
  logic [1:0] cell_dir;
  logic [1:0] cell_pol;
  logic [1:0] cell_alen;
  logic [1:0] cell_dat;
  logic [7:0] data_view;

  // ==========================================================================
  // Write decode
  // ==========================================================================
  pin_write_decode u_decode (
    .clk(clk),
    .reset(reset),
    .req(wr_req),
    .ctrl_we(ctrl_we),
    .data_we(data_we),
    .wdata(wdata)
  );

  // ==========================================================================
  // Field mapping, index 0 is pin three, index 1 pin four
  // ==========================================================================
  assign cell_en[0] = s_q.ctrl[THREE_FSEL_BIT];
  assign cell_en[1] = 1'b1;
  assign cell_dir[0] = s_q.ctrl[THREE_DIR_BIT];
  assign cell_dir[1] = s_q.ctrl[FOUR_DIR_BIT];
  assign cell_pol[0] = s_q.ctrl[THREE_POL_BIT];
  assign cell_pol[1] = s_q.ctrl[FOUR_POL_BIT];
  assign cell_alen[0] = s_q.ctrl[THREE_ALEN_BIT];
  assign cell_alen[1] = s_q.ctrl[FOUR_ALEN_BIT];
  assign cell_dat[0] = s_q.data[THREE_DATA_BIT];
  assign cell_dat[1] = s_q.data[FOUR_DATA_BIT];

  // ==========================================================================
  // Pin cells
  // ==========================================================================
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_pin
      pin_cell u_cell (
        .clk(clk),
        .reset(reset),
        .enable(cell_en[i]),
        .direction(cell_dir[i]),
        .polarity(cell_pol[i]),
        .alert_enable(cell_alen[i]),
        .data_bit(cell_dat[i]),
        .pin_in(pin_in[i]),
        .drive_out(cell_out[i]),
        .drive_oe(cell_oe[i]),
        .level(cell_level[i]),
        .alert(cell_alert[i])
      );
    end
  endgenerate

  // ==========================================================================
  // Data readback: input pins show sampled level, except pin three in its analog role, which shows the stored bit
  // ==========================================================================
  always_comb
  begin
    data_view = s_q.data;
    data_view[3:0] = 4'h0;
    if (cell_en[0] && cell_dir[0])
      data_view[THREE_DATA_BIT] = cell_level[0];
    if (cell_dir[1])
      data_view[FOUR_DATA_BIT] = cell_level[1];
    data_view[TWO_DATA_BIT] = pin_low_level[0];
    data_view[ONE_DATA_BIT] = pin_low_level[1];
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  always_comb
  begin
    s_d = s_q;
    if (ctrl_we)
      s_d.ctrl = wdata;
    if (data_we)
      s_d.data = {wdata[7:4], 4'h0};
    s_d.rsp.valid = rd_req.valid;
    s_d.rsp.data = 8'h00;
    if (rd_req.valid)
    begin
      case (rd_req.addr)
        RD_ADDR_CTRL: s_d.rsp.data = s_q.ctrl;
        RD_ADDR_DATA: s_d.rsp.data = data_view;
        default: s_d.rsp.data = 8'h00;
      endcase
    end
    s_d.drive.out = cell_out;
    s_d.drive.oe = cell_oe;
    s_d.alert = |cell_alert;
    s_d.aux_sel = !s_q.ctrl[THREE_FSEL_BIT];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.data <= DATA_RESET;
      s_q.aux_sel <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign rd_rsp = s_q.rsp;
  assign pin_drive = s_q.drive;
  assign pin_alert = s_q.alert;
  assign third_auxiliary_input_select = s_q.aux_sel;
  assign pin_low_data = {s_q.data[ONE_DATA_BIT], s_q.data[TWO_DATA_BIT]};

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_ctrl_write_read: assert property (
    @(posedge clk) disable iff (reset)
    (rd_req.valid && rd_req.addr == RD_ADDR_CTRL && !ctrl_we)
    |=> (rd_rsp.valid && rd_rsp.data == $past(s_q.ctrl)))
    else $error("control readback mismatch");

  a_four_output: assert property (
    @(posedge clk) disable iff (reset)
    (!s_q.ctrl[FOUR_DIR_BIT] && !ctrl_we) [*3] |-> pin_drive.oe[1])
    else $error("pin four not driven as output");

  a_three_aux: assert property (
    @(posedge clk) disable iff (reset)
    (!s_q.ctrl[THREE_FSEL_BIT] [*3]) |-> !pin_drive.oe[0])
    else $error("pin three driven in analog role");

  a_three_dir: assert property (
    @(posedge clk) disable iff (reset)
    (s_q.ctrl[THREE_DIR_BIT] [*3]) |-> !pin_drive.oe[0])
    else $error("pin three driven while input");

  a_four_alert: assert property (
    @(posedge clk) disable iff (reset)
    (s_q.ctrl[2:0] == 3'h7 && pin_in[1]) [*3] |-> pin_alert)
    else $error("pin four alert missing");

  a_four_low: assert property (
    @(posedge clk) disable iff (reset)
    (s_q.ctrl[2:0] == 3'h3 && !pin_in[1]) [*3] |-> pin_alert)
    else $error("pin four active low alert missing");

  a_three_alert: assert property (
    @(posedge clk) disable iff (reset)
    (s_q.ctrl[7:4] == 4'hF && pin_in[0]) [*3] |-> pin_alert)
    else $error("pin three alert missing");

  a_three_pol: assert property (
    @(posedge clk) disable iff (reset)
    (s_q.ctrl[7:4] == 4'hB && !pin_in[0]) [*3] |-> pin_alert)
    else $error("pin three active low alert missing");

  a_masked_quiet: assert property (
    @(posedge clk) disable iff (reset)
    ((s_q.ctrl[FOUR_ALEN_BIT] == 1'b0 && s_q.ctrl[THREE_ALEN_BIT] == 1'b0) [*3]) |-> !pin_alert)
    else $error("alert while both masked");

  a_data_read: assert property (
    @(posedge clk) disable iff (reset)
    (rd_req.valid && rd_req.addr == RD_ADDR_DATA) |=> (rd_rsp.valid && rd_rsp.data[3:0] == 4'h0))
    else $error("unused data bits not zero");

  a_drive_data: assert property (
    @(posedge clk) disable iff (reset)
    (!data_we [*3]) |-> (pin_drive.out[1] == s_q.data[FOUR_DATA_BIT]))
    else $error("pin four drive differs from data bit");

  a_ctrl_lands: assert property (
    @(posedge clk) disable iff (reset)
    ctrl_we |=> (s_q.ctrl == $past(wdata)))
    else $error("control write lost");

  a_data_lands: assert property (
    @(posedge clk) disable iff (reset)
    data_we |=> (s_q.data == {$past(wdata[7:4]), 4'h0}))
    else $error("data write lost");

  a_read_pulse: assert property (
    @(posedge clk) disable iff (reset)
    !rd_req.valid |=> !rd_rsp.valid)
    else $error("read answer without request");

  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (reset)
    (rd_req.valid && rd_req.addr != RD_ADDR_CTRL && rd_req.addr != RD_ADDR_DATA)
    |=> (rd_rsp.valid && rd_rsp.data == 8'h00))
    else $error("unmapped read not zero");

  a_aux_role: assert property (
    @(posedge clk) disable iff (reset)
    (!s_q.ctrl[THREE_FSEL_BIT] [*2]) |-> third_auxiliary_input_select)
    else $error("analog role not selected");

  a_gp_role: assert property (
    @(posedge clk) disable iff (reset)
    (s_q.ctrl[THREE_FSEL_BIT] [*2]) |-> !third_auxiliary_input_select)
    else $error("analog role kept in general use");

  a_four_input: assert property (
    @(posedge clk) disable iff (reset)
    (s_q.ctrl[FOUR_DIR_BIT] [*3]) |-> !pin_drive.oe[1])
    else $error("pin four driven while input");

  a_three_output: assert property (
    @(posedge clk) disable iff (reset)
    ((s_q.ctrl[THREE_FSEL_BIT] && !s_q.ctrl[THREE_DIR_BIT]) [*3]) |-> pin_drive.oe[0])
    else $error("pin three not driven as output");

  a_three_masked: assert property (
    @(posedge clk) disable iff (reset)
    ((!s_q.ctrl[THREE_ALEN_BIT]
      && !(s_q.ctrl[FOUR_ALEN_BIT] && s_q.ctrl[FOUR_DIR_BIT]
      && pin_in[1] == s_q.ctrl[FOUR_POL_BIT])) [*3]) |-> !pin_alert)
    else $error("alert from masked pin three");

  a_four_masked: assert property (
    @(posedge clk) disable iff (reset)
    ((!s_q.ctrl[FOUR_ALEN_BIT]
      && !(s_q.ctrl[THREE_FSEL_BIT] && s_q.ctrl[THREE_ALEN_BIT] && s_q.ctrl[THREE_DIR_BIT]
      && pin_in[0] == s_q.ctrl[THREE_POL_BIT])) [*3]) |-> !pin_alert)
    else $error("alert from masked pin four");

  a_analog_quiet: assert property (
    @(posedge clk) disable iff (reset)
    ((!s_q.ctrl[THREE_FSEL_BIT] && !s_q.ctrl[FOUR_ALEN_BIT]) [*3]) |-> !pin_alert)
    else $error("alert from pin three in analog role");

  a_three_drive: assert property (
    @(posedge clk) disable iff (reset)
    (!data_we [*3]) |-> (pin_drive.out[0] == s_q.data[THREE_DATA_BIT]))
    else $error("pin three drive differs from data bit");

  a_four_readback: assert property (
    @(posedge clk) disable iff (reset)
    (s_q.ctrl[FOUR_DIR_BIT] && rd_req.valid && rd_req.addr == RD_ADDR_DATA)
    |=> (rd_rsp.data[FOUR_DATA_BIT] == $past(pin_in[1], 2)))
    else $error("pin four input level not read back");

  a_three_stored: assert property (
    @(posedge clk) disable iff (reset)
    (!s_q.ctrl[THREE_FSEL_BIT] && rd_req.valid && rd_req.addr == RD_ADDR_DATA)
    |=> (rd_rsp.data[THREE_DATA_BIT] == $past(s_q.data[THREE_DATA_BIT])))
    else $error("analog pin three data bit not stored value");

endmodule // pin_block

`default_nettype wire

// file: hw/pin_pkg.sv
// Package: register map, field positions and carrier types for the pin block
package pin_pkg;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [3:0] EXT_PREFIX = 4'hF;
  localparam logic [3:0] WR_ADDR_CTRL = 4'h1;
  localparam logic [3:0] WR_ADDR_DATA = 4'h2;
  localparam logic [4:0] RD_ADDR_CTRL = 5'h1C;
  localparam logic [4:0] RD_ADDR_DATA = 5'h1D;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ==========================================================================
  // Control field positions
  // ==========================================================================
  localparam int FOUR_ALEN_BIT = 0;
  localparam int FOUR_DIR_BIT = 1;
  localparam int FOUR_POL_BIT = 2;
  localparam int THREE_ALEN_BIT = 4;
  localparam int THREE_DIR_BIT = 5;
  localparam int THREE_POL_BIT = 6;
  localparam int THREE_FSEL_BIT = 7;

  // Data field positions
  localparam int FOUR_DATA_BIT = 4;
  localparam int THREE_DATA_BIT = 5;
  localparam int TWO_DATA_BIT = 6;
  localparam int ONE_DATA_BIT = 7;

  // Write frame: 16-bit word, prefix in the top nibble
  localparam int WORD_WIDTH = 16;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } write_req_type;

  typedef struct packed {
    logic valid;
    logic [4:0] addr;
  } read_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } read_rsp_type;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } pin_drive_type;

endpackage

// file: hw/pin_write_decode.sv
// Decoder of extended-map write words into register strobes
`timescale 1ns/1ns
`default_nettype none

module pin_write_decode
  import pin_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Incoming word
  input wire write_req_type req,
  // Decoded strobes
  output logic ctrl_we,
  output logic data_we,
  output logic [7:0] wdata
);

  typedef struct packed {
    logic ctrl_we;
    logic data_we;
    logic [7:0] wdata;
  } dec_state_type;

  dec_state_type s_q;
  dec_state_type s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.ctrl_we = 1'b0;
    s_d.data_we = 1'b0;
    if (req.valid && req.word[15:12] == EXT_PREFIX)
    begin
      s_d.wdata = req.word[7:0];
      s_d.ctrl_we = (req.word[11:8] == WR_ADDR_CTRL);
      s_d.data_we = (req.word[11:8] == WR_ADDR_DATA);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign ctrl_we = s_q.ctrl_we;
  assign data_we = s_q.data_we;
  assign wdata = s_q.wdata;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_ctrl_decode: assert property (
    @(posedge clk) disable iff (reset)
    (req.valid && req.word[15:8] == 8'hF1) |=> (ctrl_we && wdata == $past(req.word[7:0])))
    else $error("control write not decoded");

  a_bad_prefix: assert property (
    @(posedge clk) disable iff (reset)
    (req.valid && req.word[15:12] != EXT_PREFIX) |=> (!ctrl_we && !data_we))
    else $error("write decoded without prefix");

endmodule // pin_write_decode

`default_nettype wire

// file: hw/pin_cell.sv
// One configurable pin: output drive, input sampling and alert detection
`timescale 1ns/1ns
`default_nettype none

module pin_cell
  import pin_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire logic enable,
  input wire logic direction,
  input wire logic polarity,
  input wire logic alert_enable,
  input wire logic data_bit,
  // Pin
  input wire logic pin_in,
  // Results
  output logic drive_out,
  output logic drive_oe,
  output logic level,
  output logic alert
);

  typedef struct packed {
    logic drive_out;
    logic drive_oe;
    logic level;
    logic alert;
  } cell_state_type;

  cell_state_type s_q;
  cell_state_type s_d;

  always_comb
  begin
    s_d.drive_oe = enable && !direction;
    s_d.drive_out = data_bit;
    s_d.level = pin_in;
    // Active level set by polarity, masked by alert enable
    s_d.alert = enable && direction && alert_enable && (pin_in == polarity);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign drive_out = s_q.drive_out;
  assign drive_oe = s_q.drive_oe;
  assign level = s_q.level;
  assign alert = s_q.alert;

  a_alert_mask: assert property (
    @(posedge clk) disable iff (reset)
    !alert_enable |=> !alert)
    else $error("alert raised while masked");

endmodule // pin_cell

`default_nettype wire

// file: testbench/host_model.sv
// Host model: writes and reads the pin registers
`timescale 1ns/1ns
`default_nettype none

module host_model
  import pin_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register access
  input wire read_rsp_type rd_rsp,
  output var write_req_type wr_req,
  output var read_req_type rd_req
);
  initial wr_req = '0;
  initial rd_req = '0;

  // ==========================================
  // Write word: prefix, address, data
  // ==========================================
  task automatic wr(input logic [3:0] pre, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_req <= '{1'b1, {pre, a, d}};
    @(posedge clk);
    wr_req <= '0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ==========================================
  // Read with bounded wait for the answer
  // ==========================================
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    int i;
    @(posedge clk);
    rd_req <= '{1'b1, a};
    @(posedge clk);
    rd_req <= '0;
    d = 8'hXX;
    for (i = 0; i < 4; i++)
    begin
      #1;
      if (rd_rsp.valid === 1'b1)
      begin
        d = rd_rsp.data;
        break;
      end
      @(posedge clk);
    end
  endtask
endmodule // host_model

`default_nettype wire

// file: testbench/tb_top.sv
// Testbench for the pin block
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import pin_pkg::*;
;
  logic clk;
  logic reset;
  logic [1:0] pin_in;
  logic [1:0] pin_low_level;
  write_req_type wr_req;
  read_req_type rd_req;
  read_rsp_type rd_rsp;
  pin_drive_type pin_drive;
  logic [1:0] pin_low_data;
  logic pin_alert;
  logic aux_sel;
  int failures;
  int check_count;
  // Ctrl, pins, expected alert
  logic [10:0] tbl [9] = '{11'h7B8, 11'h7BB, 11'h7BD, 11'h59E, 11'h599,
    11'h736, 11'h73A, 11'h7B4, 11'h7B3};

  pin_block dut_u (
    .clk(clk),
    .reset(reset),
    .wr_req(wr_req),
    .rd_req(rd_req),
    .rd_rsp(rd_rsp),
    .pin_in(pin_in),
    .pin_drive(pin_drive),
    .pin_low_level(pin_low_level),
    .pin_low_data(pin_low_data),
    .pin_alert(pin_alert),
    .third_auxiliary_input_select(aux_sel)
  );

  host_model host_u (
    .clk(clk),
    .rd_rsp(rd_rsp),
    .wr_req(wr_req),
    .rd_req(rd_req)
  );

  // ==========================================
  // Helpers
  // ==========================================
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    host_u.rd(a, d);
    check(n, d, e);
  endtask

  task automatic wc(input logic [7:0] d);
    host_u.wr(EXT_PREFIX, WR_ADDR_CTRL, d);
  endtask

  task automatic pins(input logic [1:0] v);
    @(posedge clk);
    pin_in <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic summarize;
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_reset;
    rdc(RD_ADDR_CTRL, CTRL_RESET, "ctrl reset");
    rdc(RD_ADDR_DATA, DATA_RESET, "data reset");
    check("aux sel", {7'h00, aux_sel}, 8'h01);
    check("oe", {6'h00, pin_drive.oe}, 8'h02);
  endtask

  task automatic t_output;
    pin_low_level <= 2'b01;
    wc(8'h80);
    host_u.wr(EXT_PREFIX, WR_ADDR_DATA, 8'hFF);
    check("oe out", {6'h00, pin_drive.oe}, 8'h03);
    check("out", {6'h00, pin_drive.out}, 8'h03);
    check("low data", {6'h00, pin_low_data}, 8'h03);
    check("aux gp", {7'h00, aux_sel}, 8'h00);
    rdc(RD_ADDR_CTRL, 8'h80, "ctrl rb");
    rdc(RD_ADDR_DATA, 8'h70, "data rb");
    host_u.wr(EXT_PREFIX, WR_ADDR_DATA, 8'h00);
    check("out clr", {6'h00, pin_drive.out}, 8'h00);
  endtask

  task automatic t_alert;
    int i;
    for (i = 0; i < 9; i++)
    begin
      wc(tbl[i][10:3]);
      pins(tbl[i][2:1]);
      check("alert", {7'h00, pin_alert}, {7'h00, tbl[i][0]});
    end
    check("oe in", {6'h00, pin_drive.oe}, 8'h00);
    rdc(RD_ADDR_DATA, 8'h60, "data in");
  endtask

  task automatic t_refuse;
    host_u.wr(4'hE, WR_ADDR_CTRL, 8'h10);
    host_u.wr(EXT_PREFIX, 4'h3, 8'h10);
    rdc(RD_ADDR_CTRL, 8'hF6, "bad word");
    rdc(5'h00, 8'h00, "unmapped");
    wc(8'h10);
    pins(2'b00);
    check("analog oe", {6'h00, pin_drive.oe}, 8'h02);
    check("analog sel", {7'h00, aux_sel}, 8'h01);
    check("analog alert", {7'h00, pin_alert}, 8'h00);
  endtask

  // ==========================================
  // Clock, reset, sequence, watchdog
  // ==========================================
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    reset = 1'b1;
    pin_in = 2'b00;
    pin_low_level = 2'b00;
    failures = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_output();
    t_alert();
    t_refuse();
    summarize();
  end

  initial
  begin
    #200000;
    failures++;
    summarize();
  end
endmodule // tb_top

`default_nettype wire
